// >>> bench/i2c_master_model.sv
// behavioural two-wire bus master that drives the far side of the link
`timescale 1ns/1ps
module i2c_master_model (
  input wire scl_line_in,
  input wire sda_line_in,
  output reg scl_low_out,
  output reg sda_low_out
);
  reg s; // throwaway sample
  ////////////////////////////////////////////////////////////////
  // both lines released, pull-ups make them high
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  // one bit: sda set while scl low, then wait out any stretch
  task clk(input v, output smp);
    begin
      sda_low_out = ~v;
      #20;
      scl_low_out = 1'b0;
      wait (scl_line_in === 1'b1);
      #30;
      smp = sda_line_in;
      scl_low_out = 1'b1;
      #30;
    end
  endtask
  // start: sda falls while scl high
  task start;
    begin
      sda_low_out = 1'b1;
      #40;
      scl_low_out = 1'b1;
      #30;
    end
  endtask
  // stop: sda rises while scl high, slow enough for the sync flops
  task stop;
    begin
      sda_low_out = 1'b1;
      #20;
      scl_low_out = 1'b0;
      wait (scl_line_in === 1'b1);
      #30;
      sda_low_out = 1'b0;
      #60;
    end
  endtask
  // byte out msb first, ninth bit samples the slave answer
  task wr_byte(input [7:0] b, output ack);
    integer j;
    begin
      for (j = 7; j >= 0; j = j - 1) clk(b[j], s);
      clk(1'b1, ack);
    end
  endtask
  // byte in msb first, then our own answer bit
  task rd_byte(input a, output [7:0] b);
    integer j;
    begin
      for (j = 7; j >= 0; j = j - 1) clk(1'b1, b[j]);
      clk(a, s);
    end
  endtask
endmodule // i2c_master_model

// >>> bench/i2c_slave_command_status_assertions.sv
// checker for register bus timing and the clock hold of the slave
`timescale 1ns/1ps
`include "i2c_slave_defs.vh"
module i2c_slave_command_status_assertions (
  input wire mclk_in,
  input wire rstn_in,
  input wire [9:0] address_in,
  input wire read_in,
  input wire write_in,
  input wire [31:0] writedata_in,
  input wire [3:0] byteenable_in,
  input wire [31:0] readdata_out,
  input wire waitrequest_out,
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe_out,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_out
);
  // an access completing at this edge, and what it hits
  wire done = (read_in | write_in) & ~waitrequest_out;
  wire wr_cmd = done & write_in & byteenable_in[0] & (address_in[9:2] == `IDX_COMMAND);
  wire wr_st = done & write_in & byteenable_in[0] & (address_in[9:2] == `IDX_STATUS);
  wire acc_dat = done & (read_in | byteenable_in[0]) & (address_in[9:2] == `IDX_DATA);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////////////////////////////
  property p_wait_one; $rose(read_in | write_in) |-> waitrequest_out ##1 !waitrequest_out; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait state count wrong");
  property p_idle; !(read_in | write_in) |-> !waitrequest_out; endproperty
  a_idle: assert property (p_idle) else $error("waitrequest without request");
  property p_upper; done && read_in |-> readdata_out[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("upper read lanes not zero");
  property p_cmd_zero;
    done && read_in && address_in[9:2] == `IDX_COMMAND |-> {readdata_out[7:3], readdata_out[1:0]} == 7'h00;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command bits read back");
  property p_cmd_rel; wr_cmd && writedata_in[1] && scl_oe_out |-> ##[1:2] !scl_oe_out; endproperty
  a_cmd_rel: assert property (p_cmd_rel) else $error("command kept clock held");
  property p_bad_cmd; wr_cmd && !writedata_in[1] && scl_oe_out |=> scl_oe_out [*3]; endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("invalid command released clock");
  property p_w1c; wr_st && writedata_in[7:6] == 2'h3 && scl_oe_out |-> ##[1:2] !scl_oe_out; endproperty
  a_w1c: assert property (p_w1c) else $error("flag clear kept clock held");
  property p_dat; acc_dat && scl_oe_out |-> ##[1:2] !scl_oe_out; endproperty
  a_dat: assert property (p_dat) else $error("data access kept clock held");
endmodule // i2c_slave_command_status_assertions

bind i2c_slave_command_status i2c_slave_command_status_assertions chk (.mclk_in(mclk_in), .rstn_in(rstn_in),
  .address_in(address_in), .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
  .byteenable_in(byteenable_in), .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out));

// >>> bench/i2c_slave_command_status_test.sv
// self-checking bench for the two-wire slave command and status block
`timescale 1ns/1ps
`include "i2c_slave_defs.vh"
`define CHK(a, b, m) begin n_checks = n_checks + 1; if ((a) !== (b)) begin \
  err_total = err_total + 1; $display("BAD %0t %s", $time, m); end end
module i2c_slave_command_status_test;
  reg mclk_in = 1'b0;
  reg rstn_in = 1'b0;
  reg [9:0] address_in = 10'h000;
  reg read_in = 1'b0;
  reg write_in = 1'b0;
  reg [31:0] writedata_in = 32'h0000_0000;
  reg [3:0] byteenable_in = 4'h1;
  wire [31:0] readdata_out;
  wire waitrequest_out, scl_out, scl_oe_out, sda_out, sda_oe_out, m_scl, m_sda;
  // open-drain wires with pull-ups
  wire scl_in = (scl_oe_out ? scl_out : 1'b1) & ~m_scl;
  wire sda_in = (sda_oe_out ? sda_out : 1'b1) & ~m_sda;
  integer err_total = 0;
  integer n_checks = 0;
  integer seed = 58;
  integer i;
  reg [31:0] rnd;
  reg [7:0] q, own_b, oa, b, c, d, got;
  reg ack, hit;
  localparam [9:0] A_ADR = {`IDX_ADDRESS, 2'h0}, A_ST = {`IDX_STATUS, 2'h0}, A_CMD = {`IDX_COMMAND, 2'h0};
  localparam [9:0] A_CTL = {`IDX_CONTROL, 2'h0}, A_DAT = {`IDX_DATA, 2'h0};
  i2c_slave_command_status uut (.mclk_in(mclk_in), .rstn_in(rstn_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe_out(scl_oe_out), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
  i2c_master_model m (.scl_line_in(scl_in), .sda_line_in(sda_in), .scl_low_out(m_scl), .sda_low_out(m_sda));
  ////////////////////////////////////////////////////////////////
  // 100 MHz system clock
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  // one avalon access, held until waitrequest seen low; unused lanes random
  task bus(input w, input [9:0] a, input [7:0] wd, output [7:0] rd);
    integer k;
    begin
      rnd = $random(seed);
      @(posedge mclk_in);
      address_in <= a;
      writedata_in <= {rnd[23:0], wd};
      byteenable_in <= {rnd[27:25], 1'b1};
      read_in <= ~w;
      write_in <= w;
      k = 0;
      // waitrequest looked at on each rising edge, before that edge moves it
      @(posedge mclk_in);
      while (waitrequest_out !== 1'b0 && k < 50) begin
        @(posedge mclk_in);
        k = k + 1;
      end
      rd = readdata_out[7:0];
      read_in <= 1'b0;
      write_in <= 1'b0;
      `CHK(k < 50, 1'b1, "bus hang")
    end
  endtask
  task check_reg(input [9:0] a, input [7:0] e);
    begin
      bus(1'b0, a, 8'h00, q);
      `CHK(q, e, "register value")
    end
  endtask
  // slave stretching the clock, bounded wait
  task wait_hold;
    integer k;
    begin
      k = 0;
      while (scl_oe_out !== 1'b1 && k < 3000) begin
        @(negedge mclk_in);
        k = k + 1;
      end
      `CHK(scl_oe_out, 1'b1, "clock hold")
    end
  endtask
  // start plus address byte; on a hit software checks status then answers
  task addr_phase(input [7:0] ab, input h, input [9:0] ra, input [7:0] rv, input [7:0] st);
    begin
      m.start;
      fork
        m.wr_byte(ab, ack);
        if (h) begin
          wait_hold;
          check_reg(A_ST, st);
          bus(1'b1, ra, rv, q);
        end
      join
      `CHK(ack, ~h, "address answer")
    end
  endtask
  task endt(input integer n);
    $display("test %0d done, %0d mismatches so far", n, err_total);
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // hang guard, far above the expected run of some 11 us
  initial begin
    #400000;
    `CHK(1'b0, 1'b1, "timeout")
    print_verdict;
  end
  initial begin
    repeat (6) @(posedge mclk_in);
    rstn_in <= 1'b1;
    // reset values, unmapped word, address rw, command readback
    check_reg(A_ADR, `RST_BYTE);
    check_reg(A_ST, `RST_BYTE);
    check_reg(A_CMD, `RST_BYTE);
    check_reg(A_CTL, `RST_BYTE);
    check_reg(10'h3F0, 8'h00);
    rnd = $random(seed);
    own_b = {1'b0, rnd[5:0] | 6'h04, 1'b0};
    bus(1'b1, A_ADR, own_b, q);
    check_reg(A_ADR, own_b);
    bus(1'b1, A_CMD, 8'h05, q);
    check_reg(A_CMD, 8'h04);
    bus(1'b1, A_CMD, 8'h00, q);
    endt(0);
    // address matching table; a hit is finished with command 10
    for (i = 0; i < 6; i = i + 1) begin
      rnd = $random(seed);
      b = own_b;
      oa = own_b;
      c = 8'h08;
      hit = (i == 2 || i == 3 || i == 5);
      case (i)
        0: b = own_b ^ 8'h02; // other address
        1: b = {`GC_ADDR, 1'b0}; // general call while not enabled
        2: begin
          b = {`GC_ADDR, 1'b0};
          oa = own_b | 8'h01;
        end
        3: begin
          b = {rnd[7:1], 1'b0};
          c = 8'h0A;
        end
        4: c = 8'h00; // interface off
        default: begin
          oa = {5'h1E, rnd[1:0], 1'b0};
          b = oa;
        end
      endcase
      bus(1'b1, A_CTL, c, q);
      bus(1'b1, A_ADR, oa, q);
      addr_phase(b, hit, A_CMD, 8'h02, 8'h61);
      m.stop;
      endt(i + 1);
    end
    // master write: smart-mode data read acks, then reserved code and finish
    bus(1'b1, A_ADR, own_b, q);
    bus(1'b1, A_CTL, 8'h09, q);
    addr_phase(own_b, 1'b1, A_CMD, 8'h03, 8'h61);
    d = $random(seed);
    fork
      m.wr_byte(d, ack);
      begin
        wait_hold;
        check_reg(A_ST, 8'hA1);
        check_reg(A_DAT, d);
      end
    join
    `CHK(ack, 1'b0, "smart ack")
    bus(1'b1, A_CTL, 8'h08, q);
    fork
      m.wr_byte(~d, ack);
      begin
        wait_hold;
        bus(1'b1, A_CMD, 8'h01, q);
        check_reg(A_ST, 8'hA1);
        bus(1'b1, A_CMD, 8'h06, q);
      end
    join
    `CHK(ack, 1'b1, "nack after finish")
    m.stop;
    check_reg(A_ST, 8'h01);
    endt(7);
    // master read: flag clear acks address, data byte sent, master nack
    // ack_action is nack from the last finish; code 00 rewrites it to ack
    bus(1'b1, A_CMD, 8'h00, q);
    addr_phase(own_b | 8'h01, 1'b1, A_ST, 8'hC0, 8'h63);
    wait_hold;
    check_reg(A_ST, 8'hA3);
    d = $random(seed);
    fork
      m.rd_byte(1'b1, got);
      bus(1'b1, A_DAT, d, q);
    join
    `CHK(got, d, "sent byte")
    wait_hold;
    check_reg(A_ST, 8'hB3);
    bus(1'b1, A_CMD, 8'h02, q);
    m.stop;
    endt(8);
    print_verdict;
  end
endmodule // i2c_slave_command_status_test

// >>> design/i2c_slave_command_status.v
// two-wire slave: address match, command, status and clock hold
//
// Contract
// - ack_action 0 sends ACK, 1 sends NACK
// - trigger by command write, data write, or data read in smart mode
// - flag clear after address also triggers
// - command 00 nothing, 01 reserved
// - command 10 acks if writing, then waits START
// - command 11 on address: ack, then continue
// - command 11 on data: ack when receiving
// - command 10 or 11 write releases SCL, clears flags
// - new ack_action applies before command
// - command bits and upper bits read zero
// - data flag set per byte, holds SCL
// - address flag on match or data-byte collision
// - STOP sets address flag when enabled
// - clock hold shows slave holding SCL
// - received_ack_bit holds last master ack
// - collision stops driving, START clears
// - bus error when bits not nine-multiple
// - direction taken from address byte
// - cause bit: 0 STOP, 1 address
// - match upper seven bits, general call
// - ten-bit first byte matched in hardware; code matches seven-bit addresses only
// - promiscuous mode accepts every address
// - data register access clears flags
// - bus traffic only while enabled; a flag left set at disable still holds SCL
`timescale 1ns/1ps
`include "i2c_slave_defs.vh"

module i2c_slave_command_status (
  input wire mclk_in,
  input wire rstn_in,
  input wire [9:0] address_in,
  input wire read_in,
  input wire write_in,
  input wire [31:0] writedata_in,
  input wire [3:0] byteenable_in,
  output reg [31:0] readdata_out,
  output wire waitrequest_out,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe_out,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_out
);

  ////////////////////////////////////////////////////////////////////
  // states
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_ADDR = 4'h1;
  localparam [3:0] S_HADDR = 4'h2;
  localparam [3:0] S_ACK = 4'h3;
  localparam [3:0] S_RX = 4'h4;
  localparam [3:0] S_HRX = 4'h5;
  localparam [3:0] S_TX = 4'h6;
  localparam [3:0] S_TXACK = 4'h7;
  localparam [3:0] S_HTX = 4'h8;

  // software registers
  reg [7:0] own_address_field; // own address, bit 0 general call
  reg [7:0] slave_control_a; // enables and modes
  reg ack_action; // 0 ack, 1 nack
  // status bits
  reg data_irq_flag;
  reg addr_stop_irq_flag;
  reg clock_hold_flag;
  reg received_ack_bit;
  reg collision_flag;
  reg bus_error_flag;
  reg transfer_direction_flag;
  reg addr_or_stop_cause;
  reg [7:0] slave_data_register; // received or to-send byte
  // bus-side state
  reg [3:0] state;
  reg [3:0] bitn; // bits of current byte
  reg [3:0] mod9; // bits since start, modulo nine
  reg in_frame; // a START has been seen
  reg any_bits; // at least one clock since START
  reg skip_fall; // next SCL fall only closes the START
  reg [7:0] shift; // serial shifter
  reg sda_drv; // pulling SDA low
  reg ack_nack; // pending ack is a nack
  reg [3:0] after_ack; // state after the ack bit
  reg done; // avalon answer phase
  // synchronisers
  reg scl_m;
  reg scl_s;
  reg scl_d;
  reg sda_m;
  reg sda_s;
  reg sda_d;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers, first stage read only by second
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // bus line events
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // open drain: value always low, enable pulls
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = data_irq_flag | addr_stop_irq_flag;
  assign sda_oe_out = sda_drv;

  ////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the access is taken
  wire req = read_in | write_in;
  wire acc = req & done;
  wire wr = acc & write_in & byteenable_in[0];
  wire rd = acc & read_in;
  assign waitrequest_out = req & ~done;

  wire [7:0] idx = address_in[9:2];
  wire sel_adr = (idx == `IDX_ADDRESS);
  wire sel_st = (idx == `IDX_STATUS);
  wire sel_cmd = (idx == `IDX_COMMAND);
  wire sel_ctl = (idx == `IDX_CONTROL);
  wire sel_dat = (idx == `IDX_DATA);

  // control fields
  wire en = slave_control_a[`CTL_EN];
  wire asie = slave_control_a[`CTL_ASIE];
  wire pme = slave_control_a[`CTL_PME];
  wire sme = slave_control_a[`CTL_SME];

  // command decode
  wire wr_cmd = wr & sel_cmd;
  wire [1:0] cmd = writedata_in[`CMD_LO:0];
  wire cmd_valid = wr_cmd & cmd[1];
  wire cmd_fin = cmd_valid & (cmd == `CMD_FIN);
  wire cmd_cont = cmd_valid & (cmd == `CMD_CONT);
  // new ack value used by same write
  wire ack_use = wr_cmd ? writedata_in[`CMD_ACK] : ack_action;
  // data register writes and accesses count only while the clock is held; reads always return it
  wire dat_wr = wr & sel_dat & clock_hold_flag;
  wire dat_rd = rd & sel_dat & clock_hold_flag;
  wire dat_acc = dat_wr | dat_rd;
  // write-one clears of status
  wire w1_st = wr & sel_st;
  wire clr_dif = w1_st & writedata_in[`ST_DIF];
  wire clr_asif = w1_st & writedata_in[`ST_ASIF];
  // valid command or data access clears both
  wire clr_both = cmd_valid | dat_acc;

  wire own_hit = (shift[7:1] == own_address_field[7:1]);
  wire gc_hit = own_address_field[0] & (shift[7:1] == `GC_ADDR);
  wire addr_match = pme | own_hit | gc_hit;

  ////////////////////////////////////////////////////////////////////
  // answer phase and read data
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done <= 1'b0;
      readdata_out <= `RST_WORD;
    end else begin
      done <= req & ~done;
      // read data captured in the wait cycle, stands at the take edge
      if (req & ~done) begin
        readdata_out <= `RST_WORD;
        if (sel_adr)
          readdata_out[7:0] <= own_address_field;
        else if (sel_st)
          readdata_out[7:0] <= {data_irq_flag, addr_stop_irq_flag,
            clock_hold_flag, received_ack_bit, collision_flag,
            bus_error_flag, transfer_direction_flag, addr_or_stop_cause};
        // command bits strobed, read as zero
        else if (sel_cmd)
          readdata_out[`CMD_ACK] <= ack_action;
        else if (sel_ctl)
          readdata_out[7:0] <= slave_control_a;
        else if (sel_dat)
          readdata_out[7:0] <= slave_data_register;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // plain software registers
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      own_address_field <= `RST_BYTE;
      slave_control_a <= `RST_BYTE;
      ack_action <= 1'b0;
    end else begin
      if (wr & sel_adr)
        own_address_field <= writedata_in[7:0];
      if (wr & sel_ctl)
        slave_control_a <= writedata_in[7:0] & `CTL_MASK;
      // stored in same write as command
      if (wr_cmd)
        ack_action <= writedata_in[`CMD_ACK];
    end
  end

  // starts the acknowledge bit while SCL is still held low
  task begin_ack;
    input nack;
    input [3:0] nxt;
    begin
      // drive low for ack, release for nack
      sda_drv <= ~nack;
      ack_nack <= nack;
      after_ack <= nxt;
      state <= S_ACK;
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  // flags and bus sequencer; later sets win over clears
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data_irq_flag <= 1'b0;
      addr_stop_irq_flag <= 1'b0;
      clock_hold_flag <= 1'b0;
      received_ack_bit <= 1'b0;
      collision_flag <= 1'b0;
      bus_error_flag <= 1'b0;
      transfer_direction_flag <= 1'b0;
      addr_or_stop_cause <= 1'b0;
      slave_data_register <= `RST_BYTE;
      state <= S_IDLE;
      bitn <= `BIT_ZERO;
      mod9 <= `BIT_ZERO;
      in_frame <= 1'b0;
      any_bits <= 1'b0;
      skip_fall <= 1'b0;
      shift <= `RST_BYTE;
      sda_drv <= 1'b0;
      ack_nack <= 1'b0;
      after_ack <= S_IDLE;
    end else begin
      // hold follows flags, one cycle behind
      clock_hold_flag <= data_irq_flag | addr_stop_irq_flag;
      if (clr_dif | clr_both)
        data_irq_flag <= 1'b0;
      if (clr_asif | clr_both)
        addr_stop_irq_flag <= 1'b0;
      if (w1_st & writedata_in[`ST_COLL])
        collision_flag <= 1'b0;
      if (w1_st & writedata_in[`ST_BERR])
        bus_error_flag <= 1'b0;
      // software load of the transmit byte
      if (dat_wr)
        slave_data_register <= writedata_in[7:0];

      if (!en) begin
        state <= S_IDLE;
        sda_drv <= 1'b0;
        in_frame <= 1'b0;
      end else if (start_det) begin
        // repeated start off a byte boundary
        if (in_frame & (mod9 != `BIT_ZERO))
          bus_error_flag <= 1'b1;
        collision_flag <= 1'b0;
        in_frame <= 1'b1;
        any_bits <= 1'b0;
        skip_fall <= 1'b1;
        mod9 <= `BIT_ZERO;
        bitn <= `BIT_ZERO;
        sda_drv <= 1'b0;
        state <= S_ADDR;
      end else if (stop_det) begin
        // stop off a boundary, or right after start
        if (in_frame & ((mod9 != `BIT_ZERO) | ~any_bits))
          bus_error_flag <= 1'b1;
        if (asie) begin
          addr_stop_irq_flag <= 1'b1;
          addr_or_stop_cause <= 1'b0;
        end
        in_frame <= 1'b0;
        sda_drv <= 1'b0;
        state <= S_IDLE;
      end else begin
        // count bits modulo nine at SCL fall: the rise ahead of a
        // STOP or repeated START never falls, so it is not a bit
        if (scl_fall & in_frame & skip_fall)
          skip_fall <= 1'b0;
        else if (scl_fall & in_frame) begin
          any_bits <= 1'b1;
          if (mod9 == `BIT_FRAME_LAST)
            mod9 <= `BIT_ZERO;
          else
            mod9 <= mod9 + `BIT_ONE;
        end
        case (state)
          S_IDLE: begin
            sda_drv <= 1'b0;
          end
          // address byte, msb first
          S_ADDR: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_s};
              bitn <= bitn + `BIT_ONE;
            end else if (scl_fall & (bitn == `BITS_BYTE)) begin
              bitn <= `BIT_ZERO;
              if (addr_match) begin
                addr_stop_irq_flag <= 1'b1;
                addr_or_stop_cause <= 1'b1;
                transfer_direction_flag <= shift[0];
                state <= S_HADDR;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          // address held, waiting for software
          S_HADDR: begin
            if (cmd_cont | clr_asif) begin
              if (transfer_direction_flag)
                begin_ack(ack_use, S_HTX);
              else
                begin_ack(ack_use, S_RX);
            end else if (cmd_fin) begin
              if (!transfer_direction_flag)
                begin_ack(ack_use, S_IDLE);
              else
                state <= S_IDLE;
            end
          end
          // ninth bit driven by the slave
          S_ACK: begin
            if (scl_rise & ack_nack & ~sda_s) begin
              collision_flag <= 1'b1;
              sda_drv <= 1'b0;
              state <= S_IDLE;
            end else if (scl_fall) begin
              sda_drv <= 1'b0;
              bitn <= `BIT_ZERO;
              if (ack_nack)
                state <= S_IDLE;
              else if (after_ack == S_HTX) begin
                data_irq_flag <= 1'b1;
                state <= S_HTX;
              end else
                state <= after_ack;
            end
          end
          // data byte from master
          S_RX: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_s};
              bitn <= bitn + `BIT_ONE;
            end else if (scl_fall & (bitn == `BITS_BYTE)) begin
              slave_data_register <= shift;
              data_irq_flag <= 1'b1;
              bitn <= `BIT_ZERO;
              state <= S_HRX;
            end
          end
          // received byte held, waiting for software
          S_HRX: begin
            if (cmd_cont | (sme & dat_rd))
              begin_ack(ack_use, S_RX);
            else if (cmd_fin)
              begin_ack(ack_use, S_IDLE);
          end
          // transmit hold, waiting for data
          S_HTX: begin
            // read direction: just wait for start
            if (cmd_fin)
              state <= S_IDLE;
            // release starts the next byte, no ack of ours
            else if (cmd_cont | clr_dif | dat_wr) begin
              shift <= dat_wr ? writedata_in[7:0] : slave_data_register;
              sda_drv <= dat_wr ? ~writedata_in[7] : ~slave_data_register[7];
              bitn <= `BIT_ZERO;
              state <= S_TX;
            end
          end
          // data byte to master
          S_TX: begin
            if (scl_rise & shift[7] & ~sda_s) begin
              collision_flag <= 1'b1;
              addr_stop_irq_flag <= 1'b1;
              sda_drv <= 1'b0;
              state <= S_IDLE;
            end else if (scl_fall) begin
              bitn <= bitn + `BIT_ONE;
              if (bitn == `BIT_LAST_TX) begin
                sda_drv <= 1'b0;
                state <= S_TXACK;
              end else begin
                shift <= {shift[6:0], 1'b0};
                sda_drv <= ~shift[6];
              end
            end
          end
          // master acknowledge of our byte
          S_TXACK: begin
            if (scl_rise)
              received_ack_bit <= sda_s;
            else if (scl_fall) begin
              data_irq_flag <= 1'b1;
              state <= S_HTX;
            end
          end
          default: begin
            sda_drv <= 1'b0;
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // i2c_slave_command_status

// >>> shared/i2c_slave_defs.vh
// constants for the two-wire slave command and status block
`ifndef I2C_SLAVE_DEFS_VH
`define I2C_SLAVE_DEFS_VH
// register indexes, byte address is four times the index
`define IDX_ADDRESS 8'h7C
`define IDX_STATUS 8'h7D
`define IDX_COMMAND 8'h7E
`define IDX_CONTROL 8'h7F
`define IDX_DATA 8'h80
// reset values
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000
// slave_status_register bit positions
`define ST_DIF 7
`define ST_ASIF 6
`define ST_COLL 3
`define ST_BERR 2
// slave_command_ack_register fields
`define CMD_ACK 2
`define CMD_FIN 2'h2
`define CMD_CONT 2'h3
`define CMD_LO 1
// slave_control_a bit positions, reserved bit 6 masked
`define CTL_ASIE 4
`define CTL_EN 3
`define CTL_PME 1
`define CTL_SME 0
`define CTL_MASK 8'hBF
// general call address
`define GC_ADDR 7'h00
// bit counts
`define BIT_ZERO 4'h0
`define BIT_ONE 4'h1
`define BIT_LAST_TX 4'h7
`define BITS_BYTE 4'h8
`define BIT_FRAME_LAST 4'h8
`endif
